// ---- verilog/sms_switch.sv ----
`timescale 1ns/1ns
`default_nettype none
module sms_switch
  import sms_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Switch pins.
  input wire logic select_input_one_in,
  input wire logic select_input_two_in,
  input wire logic volume_up_input_in,
  input wire logic volume_down_input_in,
  // Register port.
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  // Results.
  output logic [1:0] memory_out,
  output logic volume_inc_out,
  output logic volume_dec_out
);

  logic [31:0] ctrl;
  logic [31:0] timing;
  sms_cfg_type cfg;
  logic [15:0] tick_cnt;
  logic tick;
  logic [9:0] ms_cnt;
  logic sec_tick;
  logic [15:0] pod_cnt;
  logic por_done;
  logic lvl1, lvl2, lvl_up, lvl_dn;
  logic s1_closed, s2_closed, s1_prev, s1_press;
  logic s2_eff;
  logic [15:0] tc_cnt;
  logic [1:0] saved_mem;
  logic in_d;
  logic [3:0] valid;
  logic [1:0] lim;
  logic [1:0] static_sel;
  logic [2:0] long_s;
  logic rock_any, rock_prev, rock_dir_up;
  logic [2:0] press_s;
  logic long_hit;
  logic rock_release, rock_long_now;
  logic rock_vol, rock_mem;

  // Configuration is unpacked from the software registers.
  always_comb
  begin
    cfg.is_static = ctrl[CTRL_TYPE_BIT];
    cfg.dedicated_last = ctrl[CTRL_DEDIC_BIT];
    cfg.select_one_polarity = ctrl[CTRL_POL1_BIT];
    cfg.select_two_polarity = ctrl[CTRL_POL2_BIT];
    cfg.rocker_mode = sms_rock_type'(ctrl[CTRL_ROCK_LSB +: 2]);
    cfg.short_is_volume = ctrl[CTRL_SHORTVOL_BIT];
    cfg.valid_mask = ctrl[CTRL_VALID_LSB +: 4];
    cfg.long_secs = ctrl[CTRL_LONG_LSB +: 3];
    cfg.tcoil_ms = timing[TIM_TCOIL_LSB +: 16];
    cfg.power_on_ms = timing[TIM_POD_LSB +: 16];
  end

  // Memory A is valid whatever software writes.
  assign valid = {cfg.valid_mask[3:1], 1'b1};
  assign lim = cfg.dedicated_last ? MEM_C : MEM_D;
  assign long_s = (cfg.long_secs < LONG_MIN_S) ? LONG_MIN_S :
                  (cfg.long_secs > LONG_MAX_S) ? LONG_MAX_S : cfg.long_secs;

  // Register writes; unmapped addresses are ignored.
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ctrl <= CTRL_RESET;
      timing <= TIMING_RESET;
    end
    else if (reg_write_in)
    begin
      if (reg_addr_in == ADDR_CTRL)
        ctrl <= (reg_wdata_in & 32'h0000_7F7F) | (32'h0000_0001 << CTRL_VALID_LSB);
      else if (reg_addr_in == ADDR_TIMING)
        timing <= reg_wdata_in;
    end
  end

  // Register reads answer one cycle later; unmapped addresses read zero.
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (reg_read_in)
    begin
      unique case (reg_addr_in)
        ADDR_CTRL: reg_rdata_out <= ctrl;
        ADDR_TIMING: reg_rdata_out <= timing;
        ADDR_STATUS: reg_rdata_out <= {23'h00_0000, lvl_dn, lvl_up, s2_eff, s2_closed,
                                       s1_closed, por_done, in_d, memory_out};
        default: reg_rdata_out <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata_out <= 32'h0000_0000;
  end

  // Millisecond and second enables; seconds restart at each rocker press so a
  // short press can never be taken for a long one.
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
      ms_cnt <= 10'h000;
      sec_tick <= 1'b0;
    end
    else
    begin
      tick <= (tick_cnt == 16'(TICK_DIV - 1));
      tick_cnt <= (tick_cnt == 16'(TICK_DIV - 1)) ? 16'h0000 : tick_cnt + 16'h0001;
      sec_tick <= tick && (ms_cnt == 10'(MS_PER_SEC - 1)) && !(rock_any && !rock_prev);
      if (rock_any && !rock_prev)
        ms_cnt <= 10'h000;
      else if (tick)
        ms_cnt <= (ms_cnt == 10'(MS_PER_SEC - 1)) ? 10'h000 : ms_cnt + 10'h001;
    end
  end

  // Power-on delay; momentary presses are dropped until it expires.
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pod_cnt <= 16'h0000;
      por_done <= 1'b0;
    end
    else if (!por_done && tick)
    begin
      if (pod_cnt >= cfg.power_on_ms)
        por_done <= 1'b1;
      else
        pod_cnt <= pod_cnt + 16'h0001;
    end
  end

  sms_debounce u_deb1 (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .tick_in(tick),
    .pin_in(select_input_one_in), .level_out(lvl1));
  sms_debounce u_deb2 (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .tick_in(tick),
    .pin_in(select_input_two_in), .level_out(lvl2));
  sms_debounce u_debu (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .tick_in(tick),
    .pin_in(volume_up_input_in), .level_out(lvl_up));
  sms_debounce u_debd (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .tick_in(tick),
    .pin_in(volume_down_input_in), .level_out(lvl_dn));

  // Polarity: pull-up wiring closes to ground, so low means closed.
  assign s1_closed = lvl1 ^ cfg.select_one_polarity;
  assign s2_closed = lvl2 ^ cfg.select_two_polarity;
  assign s1_press = s1_closed && !s1_prev && por_done;
  assign rock_any = lvl_up || lvl_dn;

  // Second input as telecoil sense: closing acts at once, opening only after
  // a continuously open stretch, so a bouncing reed cannot flap memory D.
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s2_eff <= 1'b0;
      tc_cnt <= 16'h0000;
    end
    else if (s2_closed)
    begin
      s2_eff <= 1'b1;
      tc_cnt <= 16'h0000;
    end
    else if (s2_eff && tick)
    begin
      if (tc_cnt >= cfg.tcoil_ms)
        s2_eff <= 1'b0;
      else
        tc_cnt <= tc_cnt + 16'h0001;
    end
  end

  // Edge history and rocker press timing in whole seconds.
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s1_prev <= 1'b0;
      rock_prev <= 1'b0;
      rock_dir_up <= 1'b0;
      press_s <= 3'h0;
      long_hit <= 1'b0;
    end
    else
    begin
      s1_prev <= s1_closed;
      rock_prev <= rock_any;
      if (rock_any && !rock_prev)
      begin
        rock_dir_up <= lvl_up;
        press_s <= 3'h0;
        long_hit <= 1'b0;
      end
      else if (rock_any && sec_tick && !long_hit)
      begin
        press_s <= press_s + 3'h1;
        if (press_s + 3'h1 >= long_s)
          long_hit <= 1'b1;
      end
    end
  end

  // Classify rocker actions; presses inside the power-on delay are lost.
  assign rock_release = !rock_any && rock_prev && por_done;
  assign rock_long_now = rock_any && sec_tick && !long_hit && (press_s + 3'h1 >= long_s);
  always_comb
  begin
    rock_vol = 1'b0;
    rock_mem = 1'b0;
    unique case (cfg.rocker_mode)
      SMS_ROCK_VOLUME: rock_vol = rock_release;
      SMS_ROCK_MEMORY: rock_mem = rock_release;
      SMS_ROCK_MIXED:
      begin
        if (cfg.short_is_volume)
        begin
          rock_vol = rock_release && !long_hit;
          rock_mem = rock_long_now && por_done;
        end
        else
        begin
          rock_mem = rock_release && !long_hit;
          rock_vol = rock_release && long_hit;
        end
      end
      default: ;
    endcase
  end

  // Volume requests are single-cycle pulses.
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      volume_inc_out <= 1'b0;
      volume_dec_out <= 1'b0;
    end
    else
    begin
      volume_inc_out <= rock_vol && rock_dir_up;
      volume_dec_out <= rock_vol && !rock_dir_up;
    end
  end

  // Next valid memory upward within the limit, or A when none is left.
  function automatic logic [1:0] next_wrap(input logic [1:0] cur, input logic [3:0] v,
                                           input logic [1:0] top);
    logic [1:0] res;
    res = MEM_A;
    for (int k = 3; k >= 1; k--)
      if (2'(k) > cur && v[k] && 2'(k) <= top)
        res = 2'(k);
    return res;
  endfunction

  // Nearest valid memory in one direction; stays put at either end.
  function automatic logic [1:0] step(input logic [1:0] cur, input logic [3:0] v,
                                      input logic [1:0] top, input logic up);
    logic [1:0] res;
    res = cur;
    if (up)
    begin
      for (int k = 3; k >= 1; k--)
        if (2'(k) > cur && v[k] && 2'(k) <= top)
          res = 2'(k);
    end
    else
    begin
      for (int k = 0; k <= 2; k++)
        if (2'(k) < cur && v[k])
          res = 2'(k);
    end
    return res;
  endfunction

  // Static selection table; an invalid pick falls back to A.
  always_comb
  begin
    if (cfg.dedicated_last)
      static_sel = (s2_eff || s2_closed) ? MEM_D : (s1_closed ? MEM_B : MEM_A);
    else
      static_sel = {s2_closed, s1_closed};
    if (!valid[static_sel])
      static_sel = MEM_A;
  end

  // Memory selection. Static modes follow the switches every cycle, which
  // also gives the start-up memory; momentary modes start in A.
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      memory_out <= MEM_A;
      saved_mem <= MEM_A;
      in_d <= 1'b0;
    end
    else if (cfg.is_static)
    begin
      memory_out <= static_sel;
      in_d <= 1'b0;
    end
    else if (cfg.dedicated_last && s2_eff)
    begin
      if (!in_d)
        saved_mem <= memory_out;
      memory_out <= MEM_D;
      in_d <= 1'b1;
    end
    else if (in_d)
    begin
      memory_out <= saved_mem;
      in_d <= 1'b0;
    end
    else if (s1_press)
      memory_out <= next_wrap(memory_out, valid, lim);
    else if (rock_mem)
      memory_out <= step(memory_out, valid, lim, rock_dir_up);
  end

endmodule // sms_switch
`default_nettype wire

// ---- shared/sms_pkg.sv ----
// Overview of operation
// - Volume-up closure raises gain, volume-down lowers it.
// - Four memories A-D; A always valid.
// - Switch type plus dedicated flag give four modes.
// - Polarity setting decides which level means closed.
// - Mode 1: presses step valid memories, wrap.
// - Mode 2, second open: step, never D.
// - Mode 2, second closed: force D, ignore first.
// - Mode 2, second reopens: restore previous memory.
// - Mode 3: two static inputs binary-select memory.
// - Static modes start at selection; invalid gives A.
// - Mode 4: second closed gives D, else A/B.
// - Rocker modes: volume, memory select, or mixed.
// - Rocker memory mode: up higher, down lower.
// - Mixed mode: short/long threshold 1-5 s.
// - Long memory press acts at threshold, not release.
// - Volume and memory rocker modes act on release.
// - Leave D only after debounced continuous open.
// - Ignore momentary presses during power-on delay.
package sms_pkg;

  // System clock and derived timing.
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned MS_PER_SEC = 1000;
  localparam int unsigned BOUNCE_MS = 20;
  localparam logic [4:0] BOUNCE_TICKS = 5'(BOUNCE_MS / TICK_MS);

  // Register offsets (byte addresses).
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TIMING = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // Control and timing register field positions.
  localparam int unsigned CTRL_TYPE_BIT = 0;
  localparam int unsigned CTRL_DEDIC_BIT = 1;
  localparam int unsigned CTRL_POL1_BIT = 2;
  localparam int unsigned CTRL_POL2_BIT = 3;
  localparam int unsigned CTRL_ROCK_LSB = 4;
  localparam int unsigned CTRL_SHORTVOL_BIT = 6;
  localparam int unsigned CTRL_VALID_LSB = 8;
  localparam int unsigned CTRL_LONG_LSB = 12;
  localparam int unsigned TIM_TCOIL_LSB = 0;
  localparam int unsigned TIM_POD_LSB = 16;

  // Reset values.
  localparam logic [31:0] CTRL_RESET = 32'h0000_1100;
  localparam logic [31:0] TIMING_RESET = 32'h03E8_0064;

  // Long-press threshold limits in seconds.
  localparam logic [2:0] LONG_MIN_S = 3'h1;
  localparam logic [2:0] LONG_MAX_S = 3'h5;

  // Memory indices.
  localparam logic [1:0] MEM_A = 2'h0;
  localparam logic [1:0] MEM_B = 2'h1;
  localparam logic [1:0] MEM_C = 2'h2;
  localparam logic [1:0] MEM_D = 2'h3;

  typedef enum logic [1:0] {
    SMS_ROCK_VOLUME = 2'b00,
    SMS_ROCK_MEMORY = 2'b01,
    SMS_ROCK_MIXED = 2'b10,
    SMS_ROCK_SPARE = 2'b11
  } sms_rock_type;

  typedef struct packed {
    logic is_static;
    logic dedicated_last;
    logic select_one_polarity;
    logic select_two_polarity;
    sms_rock_type rocker_mode;
    logic short_is_volume;
    logic [3:0] valid_mask;
    logic [2:0] long_secs;
    logic [15:0] tcoil_ms;
    logic [15:0] power_on_ms;
  } sms_cfg_type;

endpackage

// ---- verilog/sms_debounce.sv ----
`timescale 1ns/1ns
`default_nettype none
module sms_debounce
  import sms_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Millisecond enable and raw pin.
  input wire logic tick_in,
  input wire logic pin_in,
  // Filtered level.
  output logic level_out
);

  logic [2:0] sync_q;
  logic [4:0] stable_cnt;
  logic agreed;

  // Three-stage synchroniser; only the last two stages are compared.
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      sync_q <= 3'h0;
    else
      sync_q <= {sync_q[1:0], pin_in};
  end

  assign agreed = (sync_q[1] == sync_q[2]);

  // The level follows only once the input held steady for the bounce time,
  // so contact chatter never yields a second edge.
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      stable_cnt <= 5'h00;
      level_out <= 1'b0;
    end
    else if (!agreed || sync_q[2] == level_out)
      stable_cnt <= 5'h00;
    else if (tick_in)
    begin
      if (stable_cnt == BOUNCE_TICKS - 5'h01)
      begin
        level_out <= sync_q[2];
        stable_cnt <= 5'h00;
      end
      else
        stable_cnt <= stable_cnt + 5'h01;
    end
  end

endmodule // sms_debounce
`default_nettype wire

// ---- bench/sms_switch_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module sms_switch_props
  import sms_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Rocker pins and register port.
  input wire logic volume_up_input_in,
  input wire logic volume_down_input_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_read_in,
  input wire logic [31:0] reg_rdata_out,
  // Results.
  input wire logic [1:0] memory_out,
  input wire logic volume_inc_out,
  input wire logic volume_dec_out
);
  default clocking dc @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  // One pulse per press, so a press is never counted twice.
  a_inc_one_cycle: assert property (volume_inc_out |=> !volume_inc_out)
    else $error("volume up pulse too long");
  a_dec_one_cycle: assert property (volume_dec_out |=> !volume_dec_out)
    else $error("volume down pulse too long");
  a_pulse_exclusive: assert property (!(volume_inc_out && volume_dec_out))
    else $error("volume up and down together");
  // Volume acts only once the rocker has been open for a while.
  a_inc_after_release: assert property (
    volume_inc_out |-> !volume_up_input_in && !$past(volume_up_input_in, 8))
    else $error("volume up before release");
  a_dec_after_release: assert property (
    volume_dec_out |-> !volume_down_input_in && !$past(volume_down_input_in, 8))
    else $error("volume down before release");
  // The part starts in memory A and stays quiet while power comes up.
  a_reset_mem_a: assert property ($rose(nrst_in) |-> memory_out == MEM_A)
    else $error("memory not A after reset");
  a_quiet_boot: assert property (
    $rose(nrst_in) |-> (!volume_inc_out && !volume_dec_out) [*8])
    else $error("volume pulse at power-on");
  // Memory A can never be marked invalid.
  a_ctrl_a_valid: assert property (
    reg_read_in && reg_addr_in == ADDR_CTRL |=> reg_rdata_out[CTRL_VALID_LSB])
    else $error("memory A reads invalid");
  // Debounced switches cannot move the memory on consecutive cycles.
  a_mem_settles: assert property ($changed(memory_out) |=> $stable(memory_out) [*2])
    else $error("memory changed twice in a row");

  c_inc: cover property (volume_inc_out);
  c_dec: cover property (volume_dec_out);
  c_mem_d: cover property (memory_out == MEM_D);
endmodule // sms_switch_props

bind sms_switch sms_switch_props #(.TICK_DIV(TICK_DIV)) i_props (
  .clk_sys_in(clk_sys_in),
  .nrst_in(nrst_in),
  .volume_up_input_in(volume_up_input_in),
  .volume_down_input_in(volume_down_input_in),
  .reg_addr_in(reg_addr_in),
  .reg_read_in(reg_read_in),
  .reg_rdata_out(reg_rdata_out),
  .memory_out(memory_out),
  .volume_inc_out(volume_inc_out),
  .volume_dec_out(volume_dec_out)
);
`default_nettype wire

// ---- bench/sms_switch_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module sms_switch_model
(
  // Clock, closures (bit 0 one, 1 two, 2 up, 3 down) and wiring of input one.
  input wire logic clk_sys_in,
  input wire logic [3:0] closed_in,
  input wire logic pol_one_in,
  // Switch pins.
  output logic [3:0] pins_out
);
  logic [3:0] held = 4'h0;
  logic [3:0] prev = 4'h0;
  logic [2:0] chat = 3'h0;

  // Contacts chatter after every change, so one press shows many edges.
  always_ff @(posedge clk_sys_in)
  begin
    held <= closed_in;
    if (closed_in != held)
    begin
      prev <= held;
      chat <= 3'h6;
    end
    else if (chat != 3'h0)
      chat <= chat - 3'h1;
  end

  // Pull-up wiring reads low when closed; rockers read high when closed.
  assign pins_out = (chat[0] ? prev : held) ^ {3'h0, pol_one_in};
endmodule // sms_switch_model
`default_nettype wire

// ---- bench/sms_switch_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module sms_switch_tb_top
  import sms_pkg::*;
();
  logic clk_sys_in;
  logic nrst_in;
  logic [3:0] closed;
  logic pol_one;
  logic [3:0] pins;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [31:0] rdata;
  logic [1:0] memory;
  logic inc;
  logic dec;
  int errors;
  int samples_checked;
  int pulses [2] = '{0, 0};
  int n;
  logic [1:0] steps [5];

  // System clock at 25 MHz.
  initial
  begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  sms_switch_model i_model (
    .clk_sys_in(clk_sys_in),
    .closed_in(closed),
    .pol_one_in(pol_one),
    .pins_out(pins)
  );

  // One tick per cycle keeps the second-long counts short.
  sms_switch #(.TICK_DIV(1)) i_dut (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .select_input_one_in(pins[0]),
    .select_input_two_in(pins[1]),
    .volume_up_input_in(pins[2]),
    .volume_down_input_in(pins[3]),
    .reg_addr_in(addr),
    .reg_wdata_in(wdata),
    .reg_write_in(wr_en),
    .reg_read_in(rd_en),
    .reg_rdata_out(rdata),
    .memory_out(memory),
    .volume_inc_out(inc),
    .volume_dec_out(dec)
  );

  // Volume pulses are tallied so checks can count them.
  always @(posedge clk_sys_in)
  begin
    if (inc === 1'b1)
      pulses[0] <= pulses[0] + 1;
    if (dec === 1'b1)
      pulses[1] <= pulses[1] + 1;
  end

  task automatic hold(input int c);
    repeat (c) @(posedge clk_sys_in);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    hold(1);
    wr_en <= 1'b0;
    hold(1);
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd_en <= 1'b1;
    hold(1);
    rd_en <= 1'b0;
    #1 chk(rdata, e);
    hold(1);
  endtask

  task automatic cm(input logic [1:0] e);
    #1 chk(32'(memory), 32'(e));
    hold(1);
  endtask

  // Holds are far longer than the debounce, so each press should count.
  task automatic press(input int b, input int c);
    closed[b] <= 1'b1;
    hold(c);
    closed[b] <= 1'b0;
    hold(60);
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    nrst_in = 1'b0;
    closed = 4'h0;
    pol_one = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    errors = 0;
    samples_checked = 0;
    steps = '{MEM_A, MEM_B, MEM_D, MEM_D, MEM_B};
    hold(20);
    nrst_in <= 1'b1;
    hold(1);
    // Reset values, write mask and an unmapped read.
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_TIMING, TIMING_RESET);
    rd(8'h0C, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h8000_9E80);
    rd(ADDR_CTRL, 32'h0000_1F00);
    $display("test registers done");
    // A press inside the power-on delay is dropped.
    press(0, 40);
    cm(MEM_A);
    hold(1000);
    $display("test power_on done");
    // Mode 1 steps and wraps, skipping invalid memories.
    for (int i = 1; i < 5; i++)
    begin
      press(0, 40);
      cm(2'(i % 4));
    end
    wr(ADDR_CTRL, 32'h0000_1500);
    press(0, 40);
    cm(MEM_C);
    press(0, 40);
    cm(MEM_A);
    $display("test mode_one done");
    // Mode 2: cycle without D, jump to D, restore after a clean open.
    wr(ADDR_CTRL, 32'h0000_1F02);
    for (int i = 1; i < 5; i++)
    begin
      press(0, 40);
      cm(2'(i % 3));
    end
    closed[1] <= 1'b1;
    hold(60);
    cm(MEM_D);
    rd(ADDR_STATUS, 32'h0000_006F);
    press(0, 40);
    cm(MEM_D);
    closed[1] <= 1'b0;
    hold(50);
    closed[1] <= 1'b1;
    hold(200);
    cm(MEM_D);
    closed[1] <= 1'b0;
    hold(200);
    cm(MEM_B);
    $display("test mode_two done");
    // Static modes 3 and 4 with input one wired as pull-up.
    pol_one <= 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      wr(ADDR_CTRL, (m == 1) ? 32'h0000_1F07 : 32'h0000_1F05);
      for (int s = 0; s < 4; s++)
      begin
        closed[1:0] <= 2'(s);
        hold(200);
        cm((m == 1 && s > 1) ? MEM_D : 2'(s));
      end
    end
    wr(ADDR_CTRL, 32'h0000_1305);
    closed[1:0] <= 2'h2;
    hold(200);
    cm(MEM_A);
    pol_one <= 1'b0;
    closed <= 4'h0;
    hold(200);
    $display("test static done");
    // Rocker as volume: each action comes on release.
    wr(ADDR_CTRL, 32'h0000_1F00);
    for (int b = 2; b < 4; b++)
    begin
      n = pulses[b - 2];
      closed[b] <= 1'b1;
      hold(60);
      chk(pulses[b - 2], n);
      closed[b] <= 1'b0;
      hold(60);
      chk(pulses[b - 2], n + 1);
    end
    $display("test rocker_volume done");
    // Rocker as memory select: clamps at the ends, skips invalid C.
    wr(ADDR_CTRL, 32'h0000_1B10);
    n = pulses[0] + pulses[1];
    for (int i = 0; i < 7; i++)
    begin
      press((i < 3 || i == 6) ? 3 : 2, 40);
      if (i > 1)
        cm(steps[i - 2]);
    end
    chk(pulses[0] + pulses[1], n);
    $display("test rocker_memory done");
    // Mixed mode with short presses as volume, then as memory.
    wr(ADDR_CTRL, 32'h0000_1B60);
    n = pulses[0];
    press(2, 40);
    chk(pulses[0], n + 1);
    cm(MEM_B);
    closed[2] <= 1'b1;
    hold(2100);
    cm(MEM_D);
    closed[2] <= 1'b0;
    hold(60);
    chk(pulses[0], n + 1);
    wr(ADDR_CTRL, 32'h0000_1B20);
    press(3, 40);
    cm(MEM_B);
    n = pulses[1];
    press(3, 2100);
    chk(pulses[1], n + 1);
    cm(MEM_B);
    $display("test mixed done");
    complete_run();
  end
endmodule // sms_switch_tb_top
`default_nettype wire
